// [hw/adc_ctrl_pkg.sv]
// Register map, field positions and shared types of the converter front end
package adc_ctrl_pkg;
  // ==========================================================================
  // Register map: each register owns a 0x10 block (base, clear, set, invert); result words answer only at base
  localparam logic [4:0] IDX_CON1 = 5'h00;
  localparam logic [4:0] IDX_CON2 = 5'h01;
  localparam logic [4:0] IDX_CON3 = 5'h02;
  localparam logic [4:0] IDX_CHS = 5'h03;
  localparam logic [4:0] IDX_PCFG = 5'h04;
  localparam logic [4:0] IDX_CSSL = 5'h05;
  localparam logic [4:0] IDX_BUF0 = 5'h06;
  localparam logic [4:0] IDX_LAST = 5'h15;
  localparam int NUM_CTL = 6;
  localparam int NUM_BUF = 16;
  localparam logic [1:0] ALIAS_BASE = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;
  // ==========================================================================
  // Implemented writable bits per control register
  localparam logic [31:0] MASK_CON1 = 32'h0000_a7f7;
  localparam logic [31:0] MASK_CON2 = 32'h0000_f43f;
  localparam logic [31:0] MASK_CON3 = 32'h0000_9fff;
  localparam logic [31:0] MASK_CHS = 32'h8f8f_0000;
  localparam logic [31:0] MASK_PCFG = 32'h0000_ffff;
  localparam logic [31:0] MASK_CSSL = 32'h0000_ffff;
  localparam logic [31:0] RESET_CTL = 32'h0000_0000;
  // ==========================================================================
  // Field positions
  localparam int C1_ON = 15;
  localparam int C1_FORM = 8;
  localparam int C1_SSRC = 5;
  localparam int C1_STOP_ON_FIRST_IRQ = 4;
  localparam int C1_SAMPLE_AUTOSTART = 2;
  localparam int C1_SAMPLE_ACTIVE = 1;
  localparam int C1_DONE = 0;
  localparam int C2_VCFG = 13;
  localparam int C2_OFFSET_CALIBRATION = 12;
  localparam int C2_SCAN_ENABLE = 10;
  localparam int C2_BUFFER_HALF_STATUS = 7;
  localparam int C2_SMPI = 2;
  localparam int C2_SPLIT_BUFFER_MODE = 1;
  localparam int C2_ALTERNATE_MUX_MODE = 0;
  localparam int C3_CONVERSION_CLOCK_SOURCE = 15;
  localparam int C3_SAMC = 8;
  localparam int C3_ADCS = 0;
  localparam int CHS_NB = 31;
  localparam int CHS_SB = 24;
  localparam int CHS_NA = 23;
  localparam int CHS_SA = 16;
  // ==========================================================================
  // Trigger sources and output formats
  localparam logic [2:0] TRIG_SOFT = 3'h0;
  localparam logic [2:0] TRIG_PIN = 3'h1;
  localparam logic [2:0] TRIG_TIMER = 3'h2;
  localparam logic [2:0] TRIG_COUNT = 3'h7;
  localparam logic [2:0] FMT_INT16 = 3'h0;
  localparam logic [2:0] FMT_FRAC16 = 3'h2;
  localparam logic [2:0] FMT_SFRAC16 = 3'h3;
  localparam logic [2:0] FMT_INT32 = 3'h4;
  localparam logic [2:0] FMT_SINT32 = 3'h5;
  localparam logic [2:0] FMT_FRAC32 = 3'h6;
  localparam logic [2:0] FMT_SFRAC32 = 3'h7;
  localparam logic [3:0] HALF_SPLIT = 4'h8;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic sample;
    logic convert_start;
    logic [3:0] pos_sel;
    logic neg_sel;
    logic [2:0] reference_config;
    logic offset_calibration;
    logic conversion_clock_source;
  } analog_ctrl_t;
endpackage : adc_ctrl_pkg

// [hw/adc_control_register_interface.sv]
// Register front end and conversion sequencer of the 10-bit converter
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Unimplemented locations and bits read zero
// - Clear alias at +0x4 clears bits
// - Set alias at +0x8 sets bits
// - Invert alias at +0xC toggles bits
// - Sixteen readable 32-bit result words
// - Result reformatted to 32 bits on read
// - Two mux settings, switched between conversions only
// - Scan converts only selected channels
// - One analog/digital bit per pin
// - Per setting 4-bit positive, 1-bit negative select
// - Control registers implement low 16 bits, except input select, which implements upper 16 bits
// - Channel selectors address sixteen channels
// - Differential conversion against selected negative input
// - Three-bit format field selects read-out format
// - Three-bit trigger field selects sampling end
// - Auto sampling clears done at sample start
// - Stop option clears auto-start on interrupt
module adc_control_register_interface (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [8:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_trigger,
  input wire logic timer_match,
  input wire logic conv_done,
  input wire logic [9:0] conv_data,
  output adc_ctrl_pkg::analog_ctrl_t analog_ctrl,
  output logic [15:0] pin_digital_mode_bit,
  output logic conv_irq
);

  // ==========================================================================
  // Storage
  logic [31:0] ctl [adc_ctrl_pkg::NUM_CTL];
  logic [9:0] result_mem [adc_ctrl_pkg::NUM_BUF];
  logic buffer_half_status;
  logic [3:0] wr_ptr;
  logic [3:0] seq_cnt;
  logic [3:0] scan_ch;
  logic use_mux_b;
  logic [14:0] sample_active_cnt;
  adc_ctrl_pkg::seq_state_t state;
  adc_ctrl_pkg::seq_state_t next_state;
  logic [31:0] next_con1;
  logic [31:0] read_value;
  logic addr_ok;

  // ==========================================================================
  // Field views
  logic [4:0] idx;
  logic [1:0] alias_sel;
  logic ctl_hit;
  logic wr_fire;
  logic [2:0] output_format_select;
  logic [2:0] trigger_source_select;
  logic [3:0] sequences_per_irq;
  logic [4:0] auto_sample_time;
  logic [7:0] conversion_clock_divider;
  logic [9:0] tad_cycles;
  logic [14:0] sample_target;
  logic trig_fire;
  logic hw_set_sample_active;
  logic hw_clear_sample_active;
  logic conv_finish;
  logic irq_fire;

  assign idx = paddr[8:4];
  assign alias_sel = paddr[3:2];
  assign ctl_hit = (paddr[1:0] == 2'h0) && (idx < adc_ctrl_pkg::IDX_BUF0);
  // Write takes effect only at the access edge; pready is high from the first clock after reset
  assign wr_fire = psel && penable && pwrite && pready;
  assign output_format_select = ctl[0][adc_ctrl_pkg::C1_FORM +: 3];
  assign trigger_source_select = ctl[0][adc_ctrl_pkg::C1_SSRC +: 3];
  assign sequences_per_irq = ctl[1][adc_ctrl_pkg::C2_SMPI +: 4];
  assign auto_sample_time = ctl[2][adc_ctrl_pkg::C3_SAMC +: 5];
  assign conversion_clock_divider = ctl[2][adc_ctrl_pkg::C3_ADCS +: 8];
  // One conversion clock period is 2 * (divider + 1) system clocks
  assign tad_cycles = {1'b0, conversion_clock_divider, 1'b0} + 10'h002;
  assign sample_target = 15'(auto_sample_time * tad_cycles);

  function automatic logic [31:0] mask_of(input int i);
    case (i)
      0: mask_of = adc_ctrl_pkg::MASK_CON1;
      1: mask_of = adc_ctrl_pkg::MASK_CON2;
      2: mask_of = adc_ctrl_pkg::MASK_CON3;
      3: mask_of = adc_ctrl_pkg::MASK_CHS;
      4: mask_of = adc_ctrl_pkg::MASK_PCFG;
      default: mask_of = adc_ctrl_pkg::MASK_CSSL;
    endcase
  endfunction : mask_of

  function automatic logic [31:0] alias_write(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [31:0] mask,
    input logic [1:0] al
  );
    logic [31:0] r;
    case (al)
      adc_ctrl_pkg::ALIAS_BASE: r = wd;
      adc_ctrl_pkg::ALIAS_CLR: r = old & ~wd;
      adc_ctrl_pkg::ALIAS_SET: r = old | wd;
      adc_ctrl_pkg::ALIAS_INV: r = old ^ wd;
      default: r = old;
    endcase
    alias_write = r & mask;
  endfunction : alias_write

  // Raw code is offset binary; signed formats flip the top bit
  function automatic logic [31:0] format_result(input logic [9:0] d, input logic [2:0] f);
    logic [9:0] s;
    s = {~d[9], d[8:0]};
    case (f)
      adc_ctrl_pkg::FMT_FRAC16: format_result = {16'h0000, d, 6'h00};
      adc_ctrl_pkg::FMT_SFRAC16: format_result = {16'h0000, s, 6'h00};
      adc_ctrl_pkg::FMT_INT32: format_result = {22'h000000, d};
      adc_ctrl_pkg::FMT_SINT32: format_result = {{22{s[9]}}, s};
      adc_ctrl_pkg::FMT_FRAC32: format_result = {d, 22'h000000};
      adc_ctrl_pkg::FMT_SFRAC32: format_result = {s, 22'h000000};
      default: format_result = {22'h000000, d};
    endcase
  endfunction : format_result

  // Next selected channel after the current one, wrapping round
  function automatic logic [3:0] next_scan(input logic [3:0] cur, input logic [15:0] sel);
    logic found;
    logic [3:0] cand;
    found = 1'b0;
    next_scan = cur;
    for (int i = 1; i <= 16; i++) begin
      cand = cur + 4'(i);
      if (!found && sel[cand]) begin
        next_scan = cand;
        found = 1'b1;
      end
    end
  endfunction : next_scan

  // ==========================================================================
  // Register read mux
  always_comb begin
    read_value = 32'h0000_0000;
    addr_ok = (paddr[1:0] == 2'h0) && (idx <= adc_ctrl_pkg::IDX_LAST);
    if (ctl_hit) begin
      // Alias locations read back zero; writes to them clear, set or invert bits
      if (alias_sel == adc_ctrl_pkg::ALIAS_BASE) begin
        read_value = ctl[idx[2:0]] & mask_of(int'(idx));
        if (idx == adc_ctrl_pkg::IDX_CON2) begin
          read_value[adc_ctrl_pkg::C2_BUFFER_HALF_STATUS] = buffer_half_status;
        end
      end
    end else if (addr_ok) begin
      if (alias_sel != adc_ctrl_pkg::ALIAS_BASE) begin
        addr_ok = 1'b0;
      end else begin
        read_value = format_result(result_mem[4'(idx - adc_ctrl_pkg::IDX_BUF0)],
                                   output_format_select);
      end
    end
  end

  // ==========================================================================
  // Bus slave: zero wait states, read data captured in the setup cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : read_value;
        pslverr <= !addr_ok;
      end
    end
  end

  // ==========================================================================
  // Sequencer events
  always_comb begin
    case (trigger_source_select)
      adc_ctrl_pkg::TRIG_PIN: trig_fire = pin_trigger;
      adc_ctrl_pkg::TRIG_TIMER: trig_fire = timer_match;
      adc_ctrl_pkg::TRIG_COUNT: trig_fire = (sample_active_cnt + 15'h0001) >= sample_target;
      default: trig_fire = 1'b0;
    endcase
  end

  assign hw_set_sample_active = (state == adc_ctrl_pkg::ST_IDLE) && ctl[0][adc_ctrl_pkg::C1_ON] &&
                       ctl[0][adc_ctrl_pkg::C1_SAMPLE_AUTOSTART] && !ctl[0][adc_ctrl_pkg::C1_SAMPLE_ACTIVE];
  assign hw_clear_sample_active = (state == adc_ctrl_pkg::ST_SAMPLE) && trig_fire;
  assign conv_finish = (state == adc_ctrl_pkg::ST_CONVERT) && conv_done;
  assign irq_fire = conv_finish && (seq_cnt == sequences_per_irq);

  always_comb begin
    next_state = state;
    case (state)
      adc_ctrl_pkg::ST_IDLE: begin
        if (ctl[0][adc_ctrl_pkg::C1_ON] && ctl[0][adc_ctrl_pkg::C1_SAMPLE_ACTIVE]) begin
          next_state = adc_ctrl_pkg::ST_SAMPLE;
        end
      end
      adc_ctrl_pkg::ST_SAMPLE: begin
        if (!ctl[0][adc_ctrl_pkg::C1_ON]) begin
          next_state = adc_ctrl_pkg::ST_IDLE;
        end else if (!ctl[0][adc_ctrl_pkg::C1_SAMPLE_ACTIVE]) begin
          next_state = adc_ctrl_pkg::ST_CONVERT;
        end
      end
      adc_ctrl_pkg::ST_CONVERT: begin
        if (conv_done || !ctl[0][adc_ctrl_pkg::C1_ON]) begin
          next_state = adc_ctrl_pkg::ST_IDLE;
        end
      end
      default: next_state = adc_ctrl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= adc_ctrl_pkg::ST_IDLE;
      sample_active_cnt <= 15'h0000;
    end else begin
      state <= next_state;
      sample_active_cnt <= (state == adc_ctrl_pkg::ST_SAMPLE) ? sample_active_cnt + 15'h0001 : 15'h0000;
    end
  end

  // ==========================================================================
  // Control registers; hardware updates win over a same-cycle software write
  always_comb begin
    next_con1 = ctl[0];
    if (wr_fire && ctl_hit && idx == adc_ctrl_pkg::IDX_CON1) begin
      next_con1 = alias_write(ctl[0], pwdata, adc_ctrl_pkg::MASK_CON1, alias_sel);
    end
    if (hw_clear_sample_active) begin
      next_con1[adc_ctrl_pkg::C1_SAMPLE_ACTIVE] = 1'b0;
    end
    if (hw_set_sample_active) begin
      next_con1[adc_ctrl_pkg::C1_SAMPLE_ACTIVE] = 1'b1;
      next_con1[adc_ctrl_pkg::C1_DONE] = 1'b0;
    end
    if (conv_finish) begin
      next_con1[adc_ctrl_pkg::C1_DONE] = 1'b1;
    end
    if (irq_fire && ctl[0][adc_ctrl_pkg::C1_STOP_ON_FIRST_IRQ]) begin
      next_con1[adc_ctrl_pkg::C1_SAMPLE_AUTOSTART] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < adc_ctrl_pkg::NUM_CTL; i++) begin
        ctl[i] <= adc_ctrl_pkg::RESET_CTL;
      end
    end else begin
      ctl[0] <= next_con1;
      for (int i = 1; i < adc_ctrl_pkg::NUM_CTL; i++) begin
        if (wr_fire && ctl_hit && idx == 5'(i)) begin
          ctl[i] <= alias_write(ctl[i], pwdata, mask_of(i), alias_sel);
        end
      end
    end
  end

  // ==========================================================================
  // Result buffer and sequence bookkeeping; result words have no write path
  always_ff @(posedge clk_sys) begin
    if (conv_finish) begin
      result_mem[wr_ptr] <= conv_data;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= 4'h0;
      seq_cnt <= 4'h0;
      buffer_half_status <= 1'b0;
      use_mux_b <= 1'b0;
      scan_ch <= 4'h0;
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= irq_fire;
      if (conv_finish) begin
        if (ctl[1][adc_ctrl_pkg::C2_SCAN_ENABLE] && !use_mux_b) begin
          scan_ch <= next_scan(analog_ctrl.pos_sel, ctl[5][15:0]);
        end
        if (irq_fire) begin
          seq_cnt <= 4'h0;
          use_mux_b <= 1'b0;
          if (ctl[1][adc_ctrl_pkg::C2_SPLIT_BUFFER_MODE]) begin
            buffer_half_status <= !buffer_half_status;
            wr_ptr <= buffer_half_status ? 4'h0 : adc_ctrl_pkg::HALF_SPLIT;
          end else begin
            wr_ptr <= 4'h0;
          end
        end else begin
          seq_cnt <= seq_cnt + 4'h1;
          wr_ptr <= wr_ptr + 4'h1;
          use_mux_b <= ctl[1][adc_ctrl_pkg::C2_ALTERNATE_MUX_MODE] && !use_mux_b;
        end
      end
    end
  end

  // ==========================================================================
  // Analog side controls; channel selection is latched only at sample start
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      analog_ctrl <= '0;
      pin_digital_mode_bit <= 16'h0000;
    end else begin
      analog_ctrl.sample <= (next_state == adc_ctrl_pkg::ST_SAMPLE);
      analog_ctrl.convert_start <= (state == adc_ctrl_pkg::ST_SAMPLE) &&
                                   (next_state == adc_ctrl_pkg::ST_CONVERT);
      analog_ctrl.reference_config <= ctl[1][adc_ctrl_pkg::C2_VCFG +: 3];
      analog_ctrl.offset_calibration <= ctl[1][adc_ctrl_pkg::C2_OFFSET_CALIBRATION];
      analog_ctrl.conversion_clock_source <= ctl[2][adc_ctrl_pkg::C3_CONVERSION_CLOCK_SOURCE];
      pin_digital_mode_bit <= ctl[4][15:0];
      if (state == adc_ctrl_pkg::ST_IDLE && next_state == adc_ctrl_pkg::ST_SAMPLE) begin
        if (use_mux_b) begin
          analog_ctrl.pos_sel <= ctl[3][adc_ctrl_pkg::CHS_SB +: 4];
          analog_ctrl.neg_sel <= ctl[3][adc_ctrl_pkg::CHS_NB];
        end else begin
          // Scan resumes at the first selected channel at or after scan_ch, so unselected inputs are skipped
          analog_ctrl.pos_sel <= ctl[1][adc_ctrl_pkg::C2_SCAN_ENABLE] ?
                                 next_scan(scan_ch - 4'h1, ctl[5][15:0]) :
                                 ctl[3][adc_ctrl_pkg::CHS_SA +: 4];
          analog_ctrl.neg_sel <= ctl[3][adc_ctrl_pkg::CHS_NA];
        end
      end
    end
  end

endmodule : adc_control_register_interface

// [tb/adc_ctrl_sva.sv]
// Port-level assertions for the converter register front end
`timescale 1ns/1ps
module adc_ctrl_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [8:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire adc_ctrl_pkg::analog_ctrl_t analog_ctrl,
  input wire logic [15:0] pin_digital_mode_bit,
  input wire logic conv_irq
);
  logic setup;
  logic rd_setup;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  assign setup = psel && !penable && (paddr[1:0] == 2'h0);
  assign rd_setup = setup && !pwrite;
  // ==========================================================================
  // Register bus
  AST_ZERO_WAIT: assert property (
    psel && penable |-> pready) else $error("access cycle without ready");
  AST_MAPPED_OK: assert property (
    setup && paddr[8:4] <= 5'h05 |=> !pslverr) else $error("error on control access");
  AST_UNMAPPED: assert property (
    setup && paddr[8:4] > 5'h15 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");
  AST_ALIAS_READ: assert property (
    rd_setup && paddr[8:4] <= 5'h05 && paddr[3:2] != 2'h0 |=> prdata == 32'h0)
    else $error("alias read not zero");
  AST_CTL_UPPER: assert property (
    rd_setup && paddr[8:4] <= 5'h02 |=> prdata[31:16] == 16'h0)
    else $error("control upper half not zero");
  AST_CHS_BITS: assert property (
    rd_setup && paddr == 9'h030 |=> (prdata & ~adc_ctrl_pkg::MASK_CHS) == 32'h0)
    else $error("input select spare bits set");
  AST_PCFG_COPY: assert property (
    rd_setup && paddr == 9'h040 |=> prdata == {16'h0, pin_digital_mode_bit})
    else $error("pin mode copy differs");
  // ==========================================================================
  // Converter link
  AST_START_EDGE: assert property (
    analog_ctrl.convert_start |-> $fell(analog_ctrl.sample) ##1 !analog_ctrl.convert_start)
    else $error("convert start misplaced");
  AST_SEL_HOLD: assert property (
    analog_ctrl.sample && $past(analog_ctrl.sample) |->
    $stable(analog_ctrl.pos_sel) && $stable(analog_ctrl.neg_sel))
    else $error("mux select moved while sampling");
  cover property (conv_irq);
  cover property (analog_ctrl.convert_start);
  cover property (psel && penable && pslverr);
endmodule : adc_ctrl_sva

bind adc_control_register_interface adc_ctrl_sva adc_ctrl_sva_i (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_ctrl(analog_ctrl),
  .pin_digital_mode_bit(pin_digital_mode_bit), .conv_irq(conv_irq));

// [tb/adc_core_model.sv]
// Behavioural converter core that answers each conversion start
`timescale 1ns/1ps
module adc_core_model #(
  parameter logic [9:0] RAW = 10'h0c5
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire adc_ctrl_pkg::analog_ctrl_t analog_ctrl,
  input wire logic [3:0] lag,
  output logic conv_done,
  output logic [9:0] conv_data
);
  logic busy;
  logic [3:0] cnt;
  // ==========================================================================
  // Lag sets a prompt or a slow answer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      conv_done <= 1'b0;
      conv_data <= 10'h0;
    end else begin
      conv_done <= 1'b0;
      // Data outside the done pulse keeps changing so it is never mistaken for valid
      conv_data <= ~conv_data;
      if (analog_ctrl.convert_start) begin
        busy <= 1'b1;
        cnt <= lag;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= RAW;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : adc_core_model

// [tb/adc_control_register_interface_tb.sv]
// Self-checking bench for the converter register front end
`timescale 1ns/1ps
module adc_control_register_interface_tb;
  localparam logic [9:0] RAW = 10'h0c5;
  localparam logic [31:0] MASKS [6] = '{adc_ctrl_pkg::MASK_CON1, adc_ctrl_pkg::MASK_CON2,
    adc_ctrl_pkg::MASK_CON3, adc_ctrl_pkg::MASK_CHS, adc_ctrl_pkg::MASK_PCFG,
    adc_ctrl_pkg::MASK_CSSL};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [8:0] paddr = 9'h0;
  logic [31:0] pwdata = 32'h0;
  logic pin_trigger = 1'b0;
  logic timer_match = 1'b0;
  logic [3:0] lag = 4'h1;
  logic [31:0] prdata, rd;
  logic pready, pslverr, conv_done, conv_irq, er;
  logic [9:0] conv_data;
  logic [15:0] pin_digital_mode_bit;
  logic [8:0] a;
  adc_ctrl_pkg::analog_ctrl_t analog_ctrl;
  int fail_count = 0;
  int n_tests = 0;
  always #12.5 clk_sys = ~clk_sys;
  adc_control_register_interface adc_control_register_interface_i (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_trigger(pin_trigger), .timer_match(timer_match), .conv_done(conv_done),
    .conv_data(conv_data), .analog_ctrl(analog_ctrl),
    .pin_digital_mode_bit(pin_digital_mode_bit), .conv_irq(conv_irq));
  adc_core_model #(.RAW(RAW)) adc_core_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .analog_ctrl(analog_ctrl), .lag(lag), .conv_done(conv_done), .conv_data(conv_data));
  // ==========================================================================
  // Tasks
  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [8:0] ad, input logic [31:0] d);
    int k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      check({31'h0, pready}, 32'h1);
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [8:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    check(rd, exp);
  endtask : rchk
  // Waits on a converter event; irq picks the interrupt, else the convert start
  task automatic wait_ev(input bit irq);
    for (int k = 0; k < 400; k++) begin
      @(negedge clk_sys);
      if (irq ? conv_irq === 1'b1 : analog_ctrl.convert_start === 1'b1) begin
        n_tests++;
        return;
      end
    end
    check(32'h0, 32'h1);
    wrap_up();
  endtask : wait_ev
  task automatic wait_done();
    for (int k = 0; k < 40; k++) begin
      apb(1'b0, 9'h000, 32'h0);
      if (rd[0] === 1'b1) return;
    end
    check({31'h0, rd[0]}, 32'h1);
    wrap_up();
  endtask : wait_done
  function automatic logic [31:0] fmt(input logic [2:0] f);
    logic [9:0] s;
    s = {~RAW[9], RAW[8:0]};
    case (f)
      3'h2: return {16'h0, RAW, 6'h0};
      3'h3: return {16'h0, s, 6'h0};
      3'h5: return {{22{s[9]}}, s};
      3'h6: return {RAW, 22'h0};
      3'h7: return {s, 22'h0};
      default: return {22'h0, RAW};
    endcase
  endfunction : fmt
  // ==========================================================================
  // Sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rchk({i[4:0], 4'h0}, 32'h0);
    for (int i = 1; i < 6; i++) begin
      a = {i[4:0], 4'h0};
      apb(1'b1, a, 32'hffff_ffff);
      rchk(a, MASKS[i]);
      apb(1'b1, a | 9'h4, 32'h5555_5555);
      rchk(a, MASKS[i] & 32'haaaa_aaaa);
      apb(1'b1, a | 9'h8, 32'hffff_ffff);
      rchk(a, MASKS[i]);
      apb(1'b1, a | 9'hc, 32'h0f0f_0f0f);
      rchk(a, MASKS[i] & 32'hf0f0_f0f0);
      rchk(a | 9'h4, 32'h0);
      apb(1'b1, a | 9'h8, 32'hffff_0000);
      rchk(a, MASKS[i] & 32'hffff_f0f0);
      apb(1'b1, a, 32'h0);
    end
    apb(1'b1, 9'h040, 32'h0000_a5a5);
    repeat (2) @(posedge clk_sys);
    check({16'h0, pin_digital_mode_bit}, 32'h0000_a5a5);
    apb(1'b0, 9'h1f0, 32'h0);
    check({31'h0, er}, 32'h1);
    // Manual sampling ended by software on mux A input 5
    apb(1'b1, 9'h030, 32'h0005_0000);
    apb(1'b1, 9'h020, 32'h0000_0100);
    apb(1'b1, 9'h000, 32'h0000_8002);
    repeat (2) @(posedge clk_sys);
    check({31'h0, analog_ctrl.sample}, 32'h1);
    check({28'h0, analog_ctrl.pos_sel}, 32'h5);
    apb(1'b1, 9'h004, 32'h0000_0002);
    wait_ev(1'b0);
    wait_done();
    for (int f = 0; f < 8; f++) begin
      apb(1'b1, 9'h000, 32'h8000 | (f << 8));
      rchk(9'h060, fmt(f[2:0]));
    end
    apb(1'b1, 9'h060, 32'hffff_ffff);
    rchk(9'h060, fmt(3'h7));
    // Pin edge and timer match end sampling; the core answers slowly here
    lag <= 4'h9;
    for (int t = 1; t < 3; t++) begin
      apb(1'b1, 9'h000, 32'h8000 | (t << 5));
      apb(1'b1, 9'h008, 32'h0000_0002);
      repeat (4) @(posedge clk_sys);
      check({31'h0, analog_ctrl.sample}, 32'h1);
      if (t == 1) pin_trigger <= 1'b1;
      else timer_match <= 1'b1;
      @(posedge clk_sys);
      pin_trigger <= 1'b0;
      timer_match <= 1'b0;
      wait_ev(1'b0);
      wait_done();
    end
    // Counter-timed auto sampling that stops at the first interrupt
    lag <= 4'h0;
    apb(1'b1, 9'h000, 32'h0000_80f4);
    wait_ev(1'b1);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, 9'h000, 32'h0);
    check({29'h0, rd[2], 2'h0}, 32'h0);
    // Auto scan over channels 4 and 5, two conversions per interrupt
    apb(1'b1, 9'h050, 32'h0000_0030);
    apb(1'b1, 9'h010, 32'h0000_0404);
    apb(1'b1, 9'h000, 32'h0000_80f4);
    for (int c = 4; c < 6; c++) begin
      wait_ev(1'b0);
      check({28'h0, analog_ctrl.pos_sel}, c);
    end
    wait_ev(1'b1);
    rchk(9'h070, fmt(3'h0));
    wrap_up();
  end
endmodule : adc_control_register_interface_tb
